//--- logic/lcd_scan_pkg.sv
// Constants and types shared by the dot-matrix display scan logic.
// Assumes a single 200 MHz clock and APB register access with 32-bit data.
package lcd_scan_pkg;

  // ==========================================================================
  // Register map (printed offsets are indices; byte address is four times)
  // ==========================================================================
  localparam logic [15:0] CONTROL_INDEX = 16'h0058;
  localparam logic [15:0] MEMORY_FIRST_INDEX = 16'h0480;
  localparam logic [15:0] MEMORY_LAST_INDEX = 16'h04bb;
  localparam logic [15:0] CONTROL_ADDR = CONTROL_INDEX << 2;
  localparam logic [15:0] MEMORY_FIRST_ADDR = MEMORY_FIRST_INDEX << 2;
  localparam logic [15:0] MEMORY_LAST_ADDR = MEMORY_LAST_INDEX << 2;

  // ==========================================================================
  // Control register fields and reset value
  // ==========================================================================
  localparam int DUTY_SELECT_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int CLOCK_DIVIDER_MSB = 5;
  localparam int CLOCK_DIVIDER_LSB = 4;
  localparam int DISPLAY_ENABLE_BIT = 3;
  localparam int CLOCK_SOURCE_BIT = 2;
  localparam int FRAME_RATE_MSB = 1;
  localparam int FRAME_RATE_LSB = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hbf;

  // ==========================================================================
  // Geometry and dividers
  // ==========================================================================
  localparam int SEGMENT_COUNT = 60;
  localparam int COMMON_COUNT = 8;
  localparam logic [2:0] QUARTER_DUTY_LAST = 3'h3;
  localparam logic [2:0] EIGHTH_DUTY_LAST = 3'h7;
  localparam logic [8:0] CORE_DIV_512_MASK = 9'h1ff;
  localparam logic [8:0] CORE_DIV_256_MASK = 9'h0ff;
  localparam logic [8:0] CORE_DIV_128_MASK = 9'h07f;
  localparam logic [8:0] CORE_DIV_64_MASK = 9'h03f;
  localparam logic [4:0] FRAME_DIV_8_LAST = 5'h07;
  localparam logic [4:0] FRAME_DIV_16_LAST = 5'h0f;
  localparam logic [4:0] FRAME_DIV_24_LAST = 5'h17;
  localparam logic [4:0] FRAME_DIV_32_LAST = 5'h1f;

  // Drive levels of the resistor ladder taps
  typedef enum logic [2:0] {
    LEVEL_GROUND = 3'b000,
    LEVEL_QUARTER = 3'b001,
    LEVEL_HALF = 3'b010,
    LEVEL_THREE_QUARTER = 3'b011,
    LEVEL_FULL = 3'b100
  } level_type;

endpackage : lcd_scan_pkg

//--- logic/lcd_clock_gen.sv
// Display input clock and segment clock tick generation.
// Assumes aux_slow_clock is an asynchronous pin; all other inputs are on ref_clk.
`timescale 1ns/1ps
module lcd_clock_gen
  import lcd_scan_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic aux_slow_clock,
  input wire logic osc_output_enable,
  input wire logic clock_source_req,
  input wire logic [1:0] clock_divider_sel,
  input wire logic [1:0] frame_rate_sel,
  input wire logic run,
  output logic clock_source_active,
  output logic segment_tick
);

  // ==========================================================================
  // Decoders
  // ==========================================================================
  function automatic logic [8:0] core_mask(input logic [1:0] sel);
    case (sel)
      2'b00: core_mask = CORE_DIV_512_MASK;
      2'b11: core_mask = CORE_DIV_256_MASK;
      2'b10: core_mask = CORE_DIV_128_MASK;
      default: core_mask = CORE_DIV_64_MASK;
    endcase
  endfunction : core_mask

  function automatic logic [4:0] frame_last(input logic [1:0] sel);
    case (sel)
      2'b00: frame_last = FRAME_DIV_8_LAST;
      2'b01: frame_last = FRAME_DIV_16_LAST;
      2'b10: frame_last = FRAME_DIV_24_LAST;
      default: frame_last = FRAME_DIV_32_LAST;
    endcase
  endfunction : frame_last

  logic [2:0] aux_sync;
  logic aux_level;
  logic aux_level_d;
  logic [8:0] core_count;
  logic [4:0] frame_count;

  // Aux pin synchroniser; level changes once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aux_sync <= 3'h0;
      aux_level <= 1'b0;
      aux_level_d <= 1'b0;
    end else begin
      aux_sync <= {aux_sync[1:0], aux_slow_clock};
      if (aux_sync[1] == aux_sync[2]) begin
        aux_level <= aux_sync[2];
      end
      aux_level_d <= aux_level;
    end
  end

  // Aux clock gated by oscillator output enable
  wire aux_gated = aux_level & osc_output_enable; // RULE8
  wire aux_rise = aux_gated & ~(aux_level_d & osc_output_enable);
  wire core_low = ~core_count[0];
  wire core_tick = (core_count & core_mask(clock_divider_sel)) == core_mask(clock_divider_sel); // RULE3
  wire input_tick = clock_source_active ? aux_rise : core_tick; // RULE6
  wire frame_wrap = frame_count == frame_last(frame_rate_sel);
  wire next_source = (core_low & ~aux_gated) ? clock_source_req : clock_source_active;

  // Core prescaler and glitch-free source switch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_count <= 9'h000;
      clock_source_active <= 1'b0;
    end else begin
      core_count <= core_count + 9'h001;
      clock_source_active <= next_source; // RULE5
    end
  end

  // Display input clock divided down to the segment clock
  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      frame_count <= 5'h00;
      segment_tick <= 1'b0;
    end else begin
      segment_tick <= input_tick & frame_wrap;
      if (input_tick) begin
        frame_count <= frame_wrap ? 5'h00 : frame_count + 5'h01; // RULE10
      end
    end
  end

endmodule : lcd_clock_gen

//--- logic/lcd_phase_seq.sv
// Section and phase sequencer of the multiplexed scan.
// Assumes segment_tick is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
module lcd_phase_seq
  import lcd_scan_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic duty_select,
  input wire logic segment_tick,
  output logic [2:0] section,
  output logic phase
);

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  wire [2:0] last_section = duty_select ? EIGHTH_DUTY_LAST : QUARTER_DUTY_LAST; // RULE1
  wire section_wrap = section >= last_section;

  // One section per tick, phase flips each completed frame
  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      section <= 3'h0;
      phase <= 1'b0;
    end else if (segment_tick) begin
      section <= section_wrap ? 3'h0 : section + 3'h1; // RULE11 RULE18
      if (section_wrap) begin
        phase <= ~phase; // RULE21
      end
    end
  end

endmodule : lcd_phase_seq

//--- logic/lcd_matrix_scan_control.sv
// Top level: APB registers, display memory and segment/common drive levels.
// Assumes an APB master on ref_clk and an external resistor ladder on the outputs.
`timescale 1ns/1ps
// Behaviour
// RULE1: duty_select clear scans four commons, set scans all eight commons.
// RULE2: Bit 6 of display_control always reads as zero.
// RULE3: clock_divider_sel divides core clock by 512, 64, 128 or 256 (00,01,10,11).
// RULE4: display_enable clear drives all outputs to ground level.
// RULE5: clock_source_sel change applies only when both clocks are low.
// RULE6: clock_source_sel zero picks core clock, one picks the 32 kHz clock.
// RULE7: Software changes clock_source_sel only while both clocks run.
// RULE8: The 32 kHz clock is gated by the oscillator output enable.
// RULE9: Without auxiliary oscillator, software keeps clock_source_sel clear.
// RULE10: frame_rate_sel divides input clock by 8, 16, 24 or 32.
// RULE11: Frame rate is segment clock over four or over eight.
// RULE12: Display memory is one 60-byte page, one bit per dot.
// RULE13: Set memory bit turns dot on, clear bit turns it off.
// RULE14: Reset leaves the display memory untouched.
// RULE15: Bit position selects common, bit 0 common 1 to bit 7 common 8.
// RULE16: Byte offset selects segment, 00h segment 1 to 3Bh segment 60.
// RULE17: display_control is read/write and resets to zero.
// RULE18: Frame has eight sections at 1/8 duty, four at 1/4 duty.
// RULE19: Software disables display before halt unless 32 kHz clock selected.
// RULE20: Memory is dual-ported: scan reads while the processor writes.
// RULE21: Sequencer steps per segment tick, selects common, drives segments from memory.
module lcd_matrix_scan_control
  import lcd_scan_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic aux_slow_clock,
  input wire logic osc_output_enable,
  output logic clock_source_active,
  output level_type [SEGMENT_COUNT-1:0] segment_level,
  output level_type [COMMON_COUNT-1:0] common_level
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0] display_control;
  logic [7:0] segment_memory [SEGMENT_COUNT];
  logic [2:0] section;
  logic phase;
  logic segment_tick;

  // ==========================================================================
  // APB address decode
  // ==========================================================================
  function automatic logic is_memory(input logic [15:0] addr);
    is_memory = (addr[1:0] == 2'b00) && (addr >= MEMORY_FIRST_ADDR) && (addr <= MEMORY_LAST_ADDR);
  endfunction : is_memory

  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire hit_control = paddr == CONTROL_ADDR;
  wire hit_memory = is_memory(paddr);
  wire [15:0] memory_offset_wide = (paddr - MEMORY_FIRST_ADDR) >> 2;
  wire [5:0] memory_offset = memory_offset_wide[5:0]; // RULE16
  wire mapped = hit_control | hit_memory;
  wire write_control = access_phase & pwrite & hit_control;
  wire write_memory = access_phase & pwrite & hit_memory;

  // Read selection, reserved bit forced to zero
  logic [31:0] read_value;
  always_comb begin
    if (hit_control) begin
      read_value = {24'h000000, display_control & CONTROL_WRITE_MASK}; // RULE2
    end else if (hit_memory) begin
      read_value = {24'h000000, segment_memory[memory_offset]};
    end else begin
      read_value = 32'h00000000;
    end
  end

  // Answer in the access phase with no wait state
  assign pready = access_phase;

  // Read data and error captured during setup
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h00000000 : read_value;
      pslverr <= ~mapped;
    end
  end

  // ==========================================================================
  // Control register
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      display_control <= CONTROL_RESET; // RULE17
    end else if (write_control) begin
      display_control <= pwdata[7:0] & CONTROL_WRITE_MASK; // RULE2
    end
  end

  wire duty_select = display_control[DUTY_SELECT_BIT];
  wire [1:0] clock_divider_sel = display_control[CLOCK_DIVIDER_MSB:CLOCK_DIVIDER_LSB];
  wire display_enable = display_control[DISPLAY_ENABLE_BIT];
  wire clock_source_sel = display_control[CLOCK_SOURCE_BIT];
  wire [1:0] frame_rate_sel = display_control[FRAME_RATE_MSB:FRAME_RATE_LSB];

  // ==========================================================================
  // Display memory, not reset, written by the bus
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (write_memory) begin
      segment_memory[memory_offset] <= pwdata[7:0]; // RULE12 RULE14 RULE20
    end
  end

  // ==========================================================================
  // Clock generation and scan sequencing
  // ==========================================================================
  lcd_clock_gen clock_gen (
    .ref_clk(ref_clk),
    .reset(reset),
    .aux_slow_clock(aux_slow_clock),
    .osc_output_enable(osc_output_enable),
    .clock_source_req(clock_source_sel),
    .clock_divider_sel(clock_divider_sel),
    .frame_rate_sel(frame_rate_sel),
    .run(display_enable),
    .clock_source_active(clock_source_active),
    .segment_tick(segment_tick)
  );

  lcd_phase_seq phase_seq (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(display_enable),
    .duty_select(duty_select),
    .segment_tick(segment_tick),
    .section(section),
    .phase(phase)
  );

  // ==========================================================================
  // Drive level selection
  // ==========================================================================
  level_type next_common [COMMON_COUNT];
  level_type next_segment [SEGMENT_COUNT];
  level_type select_level;
  level_type idle_level;
  level_type on_level;
  level_type off_level;

  // Selected common swings full, others stay at inner taps
  assign select_level = phase ? LEVEL_GROUND : LEVEL_FULL;
  assign idle_level = phase ? LEVEL_THREE_QUARTER : LEVEL_QUARTER;
  assign on_level = phase ? LEVEL_FULL : LEVEL_GROUND;
  assign off_level = LEVEL_HALF;

  genvar c;
  generate
    for (c = 0; c < COMMON_COUNT; c++) begin : gen_common
      // Common c+1 active only in its own section
      assign next_common[c] = !display_enable ? LEVEL_GROUND : // RULE4
        ((section == c[2:0]) ? select_level : idle_level); // RULE1 RULE21

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          common_level[c] <= LEVEL_GROUND;
        end else begin
          common_level[c] <= next_common[c];
        end
      end
    end
  endgenerate

  genvar s;
  generate
    for (s = 0; s < SEGMENT_COUNT; s++) begin : gen_segment
      // Segment s+1 shows bit of the active common in byte s
      wire dot_on = segment_memory[s][section]; // RULE13 RULE15 RULE16
      assign next_segment[s] = !display_enable ? LEVEL_GROUND : // RULE4
        (dot_on ? on_level : off_level); // RULE21

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          segment_level[s] <= LEVEL_GROUND;
        end else begin
          segment_level[s] <= next_segment[s];
        end
      end
    end
  endgenerate

endmodule : lcd_matrix_scan_control

//--- dv/lcd_scan_monitor.sv
// Port checker for the scan control block, bound into its top.
// Assumes one ref_clk domain and APB traffic spaced by idle cycles.
`timescale 1ns/1ps
module lcd_scan_monitor
  import lcd_scan_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic aux_slow_clock,
  input wire logic osc_output_enable,
  input wire logic clock_source_active,
  input wire level_type [SEGMENT_COUNT-1:0] segment_level,
  input wire level_type [COMMON_COUNT-1:0] common_level
);
  // ==========================================================================
  // Shadow control and section timing
  // ==========================================================================
  logic [7:0] ctl_q;
  logic en_d;
  logic seen;
  logic primed;
  logic [15:0] gap;
  logic [15:0] core_div;
  logic [15:0] period;
  level_type [COMMON_COUNT-1:0] com_d;
  logic [3:0] sel_count;
  logic upper_sel;
  wire access = psel && penable;
  wire mapped = paddr == CONTROL_ADDR ||
    (paddr >= MEMORY_FIRST_ADDR && paddr <= MEMORY_LAST_ADDR && paddr[1:0] == 2'h0);
  wire changed = common_level != com_d;
  // Expected section length on the core source
  assign core_div = ctl_q[5:4] == 2'h0 ? 16'h0200 : ctl_q[5:4] == 2'h1 ? 16'h0040 :
    ctl_q[5:4] == 2'h2 ? 16'h0080 : 16'h0100;
  assign period = core_div * {10'h0, {1'b0, ctl_q[1:0]} + 3'h1, 3'h0};
  // Shadow of control, gap counter between section changes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl_q <= 8'h00;
      en_d <= 1'b0;
      seen <= 1'b0;
      primed <= 1'b0;
      gap <= 16'h0;
    end else begin
      if (access && pwrite && paddr == CONTROL_ADDR) begin
        ctl_q <= pwdata[7:0] & CONTROL_WRITE_MASK;
      end
      en_d <= ctl_q[3];
      // First section after enable is partial: arm only from the second change
      primed <= ctl_q[3] && (primed || changed);
      seen <= ctl_q[3] && !clock_source_active && (seen || (primed && changed));
      gap <= changed ? 16'h0 : gap + 16'h1;
    end
    com_d <= common_level;
  end
  // Count commons at full swing
  always_comb begin
    sel_count = 4'h0;
    upper_sel = 1'b0;
    for (int c = 0; c < COMMON_COUNT; c++) begin
      if (common_level[c] == LEVEL_FULL || common_level[c] == LEVEL_GROUND) begin
        sel_count = sel_count + 4'h1;
        upper_sel = upper_sel || (c >= 4);
      end
    end
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_ready_zero_wait: assert property (access |-> pready)
    else $error("pready low in access phase");
  chk_control_read: assert property (access && !pwrite && paddr == CONTROL_ADDR |-> prdata == {24'h0, ctl_q})
    else $error("control read mismatch");
  chk_error_decode: assert property (access |-> pslverr == !mapped && (mapped || prdata == 32'h0))
    else $error("address decode wrong");
  chk_disabled_ground: assert property (!ctl_q[3] && !en_d |-> segment_level == '0 && common_level == '0)
    else $error("outputs not grounded while disabled");
  chk_single_select: assert property (ctl_q[3] && en_d ##1 ctl_q[3] |-> sel_count == 4'h1)
    else $error("not exactly one common selected");
  chk_quarter_commons: assert property (ctl_q[3] && en_d ##1 ctl_q[3] && !ctl_q[7] |-> !upper_sel)
    else $error("upper common selected at quarter duty");
  chk_section_period: assert property (ctl_q[3] && seen && changed && !ctl_q[2] |-> gap == period - 16'h1)
    else $error("section length wrong");
  chk_source_follow: assert property ($changed(ctl_q[2]) |-> ##[1:100] clock_source_active == ctl_q[2])
    else $error("clock source not switched");
  cover property (access && pwrite && paddr == CONTROL_ADDR && pwdata[3]);
  cover property (access && !mapped);
  cover property (ctl_q[7] && common_level[7] == LEVEL_FULL);
endmodule : lcd_scan_monitor

bind lcd_matrix_scan_control lcd_scan_monitor mon (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .aux_slow_clock, .osc_output_enable, .clock_source_active,
  .segment_level, .common_level);

//--- dv/lcd_panel_model.sv
// Glass model: finds the selected common row and the dots that light.
// Assumes outputs carry the five ladder levels of level_type.
`timescale 1ns/1ps
module lcd_panel_model
  import lcd_scan_pkg::*;
(
  input wire level_type [SEGMENT_COUNT-1:0] segment_level,
  input wire level_type [COMMON_COUNT-1:0] common_level,
  output logic [2:0] row_index,
  output logic [3:0] row_count,
  output logic [SEGMENT_COUNT-1:0] lit_row
);
  // ==========================================================================
  // Selected row and lit dots
  // ==========================================================================
  always_comb begin
    row_index = 3'h0;
    row_count = 4'h0;
    for (int c = 0; c < COMMON_COUNT; c++) begin
      if (common_level[c] == LEVEL_FULL || common_level[c] == LEVEL_GROUND) begin
        row_index = 3'(c);
        row_count = row_count + 4'h1;
      end
    end
    // Full swing across a cell lights it
    for (int s = 0; s < SEGMENT_COUNT; s++) begin
      lit_row[s] = (common_level[row_index] == LEVEL_FULL && segment_level[s] == LEVEL_GROUND) ||
        (common_level[row_index] == LEVEL_GROUND && segment_level[s] == LEVEL_FULL);
    end
  end
endmodule : lcd_panel_model

//--- dv/test_lcd_matrix_scan_control.sv
// Self-checking bench for the scan control block.
// Assumes the panel model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module test_lcd_matrix_scan_control
  import lcd_scan_pkg::*;
;
  logic ref_clk, reset, psel, penable, pwrite, aux_slow_clock, osc_output_enable;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, clock_source_active, er;
  level_type [SEGMENT_COUNT-1:0] segment_level;
  level_type [COMMON_COUNT-1:0] common_level;
  logic [2:0] row_index;
  logic [3:0] row_count;
  logic [SEGMENT_COUNT-1:0] lit_row;
  logic [7:0] mem [SEGMENT_COUNT];
  int errors, checks, cycles;
  lcd_matrix_scan_control dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .aux_slow_clock, .osc_output_enable, .clock_source_active, .segment_level, .common_level);
  lcd_panel_model panel (.segment_level, .common_level, .row_index, .row_count, .lit_row);
  // ==========================================================================
  // Clocks and timeout
  // ==========================================================================
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Slow oscillator, phase unrelated to ref_clk
  initial begin
    aux_slow_clock = 1'b0;
    forever #201.3 aux_slow_clock = ~aux_slow_clock;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      errors++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_row(output int gap);
    logic [2:0] r;
    gap = 0;
    r = row_index;
    do begin
      @(posedge ref_clk);
      #1;
      gap++;
    end while (row_index === r);
  endtask : wait_row
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs;
    apb(1'b0, CONTROL_ADDR, 32'h0);
    check(64'h0, rd);
    apb(1'b1, CONTROL_ADDR, 32'hf3);
    apb(1'b0, CONTROL_ADDR, 32'h0);
    check(64'hb3, rd);
    apb(1'b1, 16'h0004, 32'hff);
    check(64'h1, er);
    apb(1'b0, MEMORY_LAST_ADDR + 16'h4, 32'h0);
    check(64'h100000000, {er, rd});
    apb(1'b0, MEMORY_FIRST_ADDR + 16'h1, 32'h0);
    check(64'h1, er);
    apb(1'b1, CONTROL_ADDR, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_memory;
    for (int s = 0; s < SEGMENT_COUNT; s++) begin
      mem[s] = 8'(s * 8'h25 + 8'h5b);
      apb(1'b1, MEMORY_FIRST_ADDR + 16'(4 * s), {24'h0, mem[s]});
    end
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    for (int s = 0; s < SEGMENT_COUNT; s++) begin
      apb(1'b0, MEMORY_FIRST_ADDR + 16'(4 * s), 32'h0);
      check({24'h0, mem[s]}, {er, rd});
    end
    check(64'h1, segment_level === '0 && common_level === '0);
    $display("test memory done");
  endtask : t_memory
  task automatic t_scan(input logic duty, input logic [1:0] cd, input logic [1:0] fs, input int n);
    int gap;
    int per;
    logic [2:0] prev;
    logic [SEGMENT_COUNT-1:0] col;
    per = (cd == 2'h0 ? 512 : cd == 2'h1 ? 64 : cd == 2'h2 ? 128 : 256) * 8 * (fs + 1);
    apb(1'b1, CONTROL_ADDR, {24'h0, duty, 1'b0, cd, 2'b10, fs});
    wait_row(gap);
    mem[0] = ~mem[0];
    apb(1'b1, MEMORY_FIRST_ADDR, {24'h0, mem[0]});
    wait_row(gap);
    for (int i = 0; i < n; i++) begin
      prev = row_index;
      wait_row(gap);
      for (int s = 0; s < SEGMENT_COUNT; s++)
        col[s] = mem[s][row_index];
      check(64'(per), 64'(gap));
      check(duty ? 3'(prev + 3'h1) : {1'b0, prev[1:0] + 2'h1}, row_index);
      check(col, lit_row);
      check(64'h1, row_count);
    end
    apb(1'b1, CONTROL_ADDR, 32'h0);
    $display("test scan done");
  endtask : t_scan
  task automatic t_aux;
    int gap;
    logic [2:0] r;
    apb(1'b1, CONTROL_ADDR, 32'h0c);
    repeat (200) @(posedge ref_clk);
    check(64'h1, clock_source_active);
    wait_row(gap);
    wait_row(gap);
    check(64'h1, gap >= 640 && gap <= 650);
    osc_output_enable <= 1'b0;
    repeat (200) @(posedge ref_clk);
    r = row_index;
    repeat (2000) @(posedge ref_clk);
    check(r, row_index);
    osc_output_enable <= 1'b1;
    apb(1'b1, CONTROL_ADDR, 32'h0);
    repeat (200) @(posedge ref_clk);
    check(64'h0, clock_source_active);
    $display("test aux done");
  endtask : t_aux
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    osc_output_enable = 1'b1;
    reset = 1'b1;
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_memory();
    t_scan(1'b0, 2'h1, 2'h0, 5);
    t_scan(1'b1, 2'h1, 2'h0, 9);
    for (int c = 0; c < 4; c++)
      t_scan(c[0], 2'(c), 2'h0, 2);
    for (int f = 1; f < 4; f++)
      t_scan(1'b1, 2'h1, 2'(f), 2);
    t_aux();
    end_of_test();
  end
endmodule : test_lcd_matrix_scan_control
